// File: hw/mgmt_bridge_pkg.sv
package mgmt_bridge_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on the local register port)
    // ------------------------------------------------------------
    localparam logic [11:0] TARGET_ADDRESS_OFS    = 12'h7a0;
    localparam logic [11:0] TRANSFER_VALUE_OFS    = 12'h7a4;
    localparam logic [11:0] ANSWER_WAIT_LIMIT_OFS = 12'h7a8;
    localparam logic [11:0] REQUEST_COMMAND_OFS   = 12'h7ac;
    localparam logic [11:0] ERROR_DETAIL_OFS      = 12'h7b0;
    localparam logic [11:0] IRQ_PENDING_OFS       = 12'h7b4;
    localparam logic [11:0] IRQ_ENABLE_OFS        = 12'h7b8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CMD_REQ_LSB     = 0;
    localparam int CMD_MASK_LSB    = 4;
    localparam int CMD_BUSY_BIT    = 12;
    localparam int CMD_TIMEOUT_BIT = 13;
    localparam int CMD_FAULT_BIT   = 14;
    localparam int CMD_TRIGGER_BIT = 16;
    localparam int ADDR_WIDTH      = 26;
    localparam int ADDR_ROUTE_BIT  = 27;
    localparam int ERR_TO_ROOT     = 0;
    localparam int ERR_TO_INT      = 1;
    localparam int ERR_BUSY_CMD    = 2;
    localparam int ERR_WRITE       = 3;
    localparam int ERR_ADDR_LSB    = 4;
    localparam int ERR_FLT_ROOT    = 30;
    localparam int ERR_FLT_INT     = 31;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  REQ_READ        = 2'h1;
    localparam logic [1:0]  REQ_WRITE       = 2'h2;
    localparam logic [31:0] ERR_CLEAR_ALL   = 32'hffffffff;
    localparam logic [31:0] WAIT_LIMIT_RST  = 32'h00000100;
    localparam logic [3:0]  BYTE_MASK_RST   = 4'hf;
    localparam int          SECOND_IRQ_LINE = 4;
    localparam int          CORE_IRQ_LINE   = 11;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [25:0] addr;
        logic        write;
        logic [3:0]  byteMask;
        logic [31:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic        done;
        logic        fault;
        logic [31:0] rdata;
    } bus_rsp_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01
    } bridge_state_e;

endpackage

// File: hw/wait_timer.sv
`timescale 1ns/10ps
`default_nettype none
module wait_timer
    import mgmt_bridge_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Control
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic [WIDTH-1:0] limit,
    // Status
    output logic                  expired
);
    logic [WIDTH-1:0] count;
    logic             running;

    wire atLimit = running && (count >= limit);

    always_ff @(posedge clk_sys) begin
        if (rst || stop) begin
            count   <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (start) begin
            count   <= '0;
            running <= 1'b1;
            expired <= 1'b0;
        end else if (atLimit) begin
            running <= 1'b0;
            expired <= 1'b1;
        end else begin
            expired <= 1'b0;
            if (running) begin
                count <= count + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/route_filter.sv
`timescale 1ns/10ps
`default_nettype none
module route_filter
    import mgmt_bridge_pkg::*;
#(
    parameter logic [25:0] EXCL_LIMIT = 26'h0002000
) (
    // Request
    input  wire logic [25:0] addr,
    input  wire logic        internalRoute,
    // Result
    output logic             reachable
);
    // Top-level units below the limit are only reachable through the root
    assign reachable = !internalRoute || (addr >= EXCL_LIMIT);
endmodule
`default_nettype wire

// File: hw/indirect_register_access_bridge.sv
// Function
// - Trigger bit launches bus request; code 1 reads, code 2 writes.
// - Nonexistent target sets command bit 13 after wait limit cycles.
// - Command holds byte mask 4-7, busy 12, timeout 13, fault 14.
// - Address bits 0-25 target; bit 27 chooses root or internal route.
// - Internal route cannot reach top-level unit ranges; root reaches all.
// - Root requests to silent addresses end by timeout; the bridge cannot hang.
// - Enabled pending error asserts second-level interrupt line 4.
// - Enabled bridge error reaches processor core interrupt line 11.
// - Error register layout: timeouts, busy command, write, address, faults.
// - Trigger while busy sets command-while-busy error flag.
// - Bus accepted but no target answered flags a fault.
// - Bus never answered flags a timeout.
// - Logged direction flag is set for writes, cleared for reads.
// - Writing all ones to error register clears all error details.
// - Pending error shows in irq bit 0; software clears it to acknowledge.
// - Value register drives write data and captures read data.
// - Writable wait limit sets cycles before declaring timeout.
`timescale 1ns/10ps
`default_nettype none
module indirect_register_access_bridge
    import mgmt_bridge_pkg::*;
#(
    parameter logic [25:0] INTERNAL_EXCL_LIMIT = 26'h0002000
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Local register port
    input  wire logic [11:0] regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    // Root bus
    output logic             rootValid,
    output bus_req_s         rootReq,
    input  wire bus_rsp_s    rootRsp,
    // Internal bus
    output logic             internalValid,
    output bus_req_s         internalReq,
    input  wire bus_rsp_s    internalRsp,
    // Interrupts
    output logic             secondLevelIrq,
    output logic             coreIrq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0]   targetAddress;
    logic [31:0]   transferValue;
    logic [31:0]   answerWaitLimit;
    logic [1:0]    reqCode;
    logic [3:0]    byteMask;
    logic          busy;
    logic          timeoutFlag;
    logic          faultFlag;
    logic [31:0]   errorDetail;
    logic          irqPending;
    logic          irqEnable;
    bridge_state_e state;
    logic          curWrite;
    logic          curInternal;
    logic [25:0]   curAddr;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire wrAddr   = regWrite && (regAddr == TARGET_ADDRESS_OFS);
    wire wrValue  = regWrite && (regAddr == TRANSFER_VALUE_OFS);
    wire wrLimit  = regWrite && (regAddr == ANSWER_WAIT_LIMIT_OFS);
    wire wrCmd    = regWrite && (regAddr == REQUEST_COMMAND_OFS);
    wire wrErr    = regWrite && (regAddr == ERROR_DETAIL_OFS);
    wire wrPend   = regWrite && (regAddr == IRQ_PENDING_OFS);
    wire wrEnable = regWrite && (regAddr == IRQ_ENABLE_OFS);

    wire [1:0] cmdCode   = regWdata[CMD_REQ_LSB +: 2];
    wire       trigger   = wrCmd && regWdata[CMD_TRIGGER_BIT];
    // Codes 0 and 3 launch nothing
    wire       validCode = (cmdCode == REQ_READ) || (cmdCode == REQ_WRITE);
    wire       launch    = trigger && validCode && (state == ST_IDLE);
    wire       busyCmd   = trigger && (state != ST_IDLE);

    wire [25:0] reqAddr     = targetAddress[ADDR_WIDTH-1:0];
    wire        reqInternal = targetAddress[ADDR_ROUTE_BIT];
    wire        reachable;

    // Selected bus answer
    wire bus_rsp_s selRsp  = curInternal ? internalRsp : rootRsp;
    wire           ansOk   = (state == ST_WAIT) && selRsp.done && !selRsp.fault;
    wire           ansFlt  = (state == ST_WAIT) && selRsp.done && selRsp.fault;
    wire           expired;
    // Timer ends every request, so a silent root target cannot hang the bridge
    wire           timedOut = (state == ST_WAIT) && expired && !selRsp.done;
    wire           finish   = ansOk || ansFlt || timedOut;

    // Unreachable internal-route target is refused at once as a fault
    wire           launchBad = launch && !reachable;
    wire           launchOk  = launch && reachable;

    wire errEvent = ansFlt || timedOut || busyCmd || launchBad;
    wire errWrite = busyCmd ? (cmdCode == REQ_WRITE) :
                    launchBad ? (cmdCode == REQ_WRITE) : curWrite;
    wire [25:0] errAddr = (busyCmd || launchBad) ? reqAddr : curAddr;
    wire errIsInt = (busyCmd || launchBad) ? reqInternal : curInternal;

    logic [31:0] next_errorDetail;
    always_comb begin
        next_errorDetail = errorDetail;
        if (wrErr && (regWdata == ERR_CLEAR_ALL)) begin
            next_errorDetail = '0;
        end
        // Set wins over a same-cycle clear
        if (errEvent) begin
            next_errorDetail[ERR_ADDR_LSB +: ADDR_WIDTH] = errAddr;
            next_errorDetail[ERR_WRITE] = errWrite;
        end
        if (timedOut && !curInternal) next_errorDetail[ERR_TO_ROOT] = 1'b1;
        if (timedOut && curInternal)  next_errorDetail[ERR_TO_INT]  = 1'b1;
        if (busyCmd)                  next_errorDetail[ERR_BUSY_CMD] = 1'b1;
        if ((ansFlt || launchBad) && !errIsInt) next_errorDetail[ERR_FLT_ROOT] = 1'b1;
        if ((ansFlt || launchBad) && errIsInt)  next_errorDetail[ERR_FLT_INT]  = 1'b1;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    wait_timer #(
        .WIDTH (32)
    ) u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (launchOk),
        .stop    (finish),
        .limit   (answerWaitLimit),
        .expired (expired)
    );

    route_filter #(
        .EXCL_LIMIT (INTERNAL_EXCL_LIMIT)
    ) u_route (
        .addr          (reqAddr),
        .internalRoute (reqInternal),
        .reachable     (reachable)
    );

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            targetAddress   <= '0;
            transferValue   <= '0;
            answerWaitLimit <= WAIT_LIMIT_RST;
            reqCode         <= '0;
            byteMask        <= BYTE_MASK_RST;
            irqEnable       <= 1'b0;
        end else begin
            if (wrAddr)  targetAddress   <= regWdata;
            if (wrLimit) answerWaitLimit <= regWdata;
            if (wrEnable) irqEnable      <= regWdata[0];
            if (wrCmd) begin
                reqCode  <= cmdCode;
                byteMask <= regWdata[CMD_MASK_LSB +: 4];
            end
            if (ansOk && !curWrite) begin
                transferValue <= selRsp.rdata;
            end else if (wrValue) begin
                transferValue <= regWdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Request sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state         <= ST_IDLE;
            busy          <= 1'b0;
            timeoutFlag   <= 1'b0;
            faultFlag     <= 1'b0;
            curWrite      <= 1'b0;
            curInternal   <= 1'b0;
            curAddr       <= '0;
            rootValid     <= 1'b0;
            internalValid <= 1'b0;
            rootReq       <= '0;
            internalReq   <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (launchOk) begin
                        state         <= ST_WAIT;
                        busy          <= 1'b1;
                        timeoutFlag   <= 1'b0;
                        faultFlag     <= 1'b0;
                        curWrite      <= (cmdCode == REQ_WRITE);
                        curInternal   <= reqInternal;
                        curAddr       <= reqAddr;
                        rootValid     <= !reqInternal;
                        internalValid <= reqInternal;
                        rootReq       <= '{reqAddr, cmdCode == REQ_WRITE,
                                           regWdata[CMD_MASK_LSB +: 4], transferValue};
                        internalReq   <= '{reqAddr, cmdCode == REQ_WRITE,
                                           regWdata[CMD_MASK_LSB +: 4], transferValue};
                    end else if (launchBad) begin
                        faultFlag <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (finish) begin
                        state         <= ST_IDLE;
                        busy          <= 1'b0;
                        rootValid     <= 1'b0;
                        internalValid <= 1'b0;
                        timeoutFlag   <= timedOut;
                        faultFlag     <= ansFlt;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Error and interrupt state
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            errorDetail    <= '0;
            irqPending     <= 1'b0;
            secondLevelIrq <= 1'b0;
            coreIrq        <= 1'b0;
        end else begin
            errorDetail <= next_errorDetail;
            // Event in the same cycle as the acknowledge keeps the bit set
            irqPending  <= errEvent || (irqPending && !(wrPend && regWdata[0]));
            secondLevelIrq <= irqPending && irqEnable;
            coreIrq        <= irqPending && irqEnable;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [31:0] cmdView = {15'h0000, 1'b0, 1'b0, faultFlag, timeoutFlag, busy,
                           4'h0, byteMask, 2'h0, reqCode};
    logic [31:0] next_rdata;
    always_comb begin
        case (regAddr)
            TARGET_ADDRESS_OFS:    next_rdata = targetAddress;
            TRANSFER_VALUE_OFS:    next_rdata = transferValue;
            ANSWER_WAIT_LIMIT_OFS: next_rdata = answerWaitLimit;
            REQUEST_COMMAND_OFS:   next_rdata = cmdView;
            ERROR_DETAIL_OFS:      next_rdata = errorDetail;
            IRQ_PENDING_OFS:       next_rdata = {31'h0, irqPending};
            IRQ_ENABLE_OFS:        next_rdata = {31'h0, irqEnable};
            default:               next_rdata = '0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdata <= '0;
        end else if (regRead) begin
            regRdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence launchSeq;
        launchOk;
    endsequence

    busy_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
        launchSeq |=> busy) else $error("busy did not rise after trigger");
    busy_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        busy && !finish |=> busy) else $error("busy fell without an answer");
    timeout_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        timedOut |=> timeoutFlag && !busy) else $error("timeout not flagged");
    route_pick_a: assert property (@(posedge clk_sys) disable iff (rst)
        launchOk |=> (internalValid == targetAddress[ADDR_ROUTE_BIT])
            && (rootValid != internalValid))
        else $error("wrong route chosen");
    busy_cmd_a: assert property (@(posedge clk_sys) disable iff (rst)
        busyCmd |=> errorDetail[ERR_BUSY_CMD]) else $error("busy command not logged");
    fault_log_a: assert property (@(posedge clk_sys) disable iff (rst)
        ansFlt |=> faultFlag && (errorDetail[ERR_FLT_ROOT] || errorDetail[ERR_FLT_INT]))
        else $error("fault not logged");
    err_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrErr && regWdata == ERR_CLEAR_ALL && !errEvent |=> errorDetail == 32'h0)
        else $error("error detail not cleared");
    irq_line_a: assert property (@(posedge clk_sys) disable iff (rst)
        irqPending && irqEnable |=> secondLevelIrq && coreIrq) else $error("irq not raised");
    read_data_a: assert property (@(posedge clk_sys) disable iff (rst)
        ansOk && !curWrite |=> transferValue == $past(selRsp.rdata)) else $error("read data lost");
endmodule
`default_nettype wire

// File: tb/bus_target_model.sv
`timescale 1ns/10ps
`default_nettype none
module bus_target_model
    import mgmt_bridge_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Request side
    input  wire logic       valid,
    input  wire bus_req_s   req,
    input  wire logic [7:0] delay,
    // Answer side
    output bus_rsp_s        rsp
);
    // ------------------------------------------------------------
    // Word store and answer timing
    // ------------------------------------------------------------
    logic [31:0] mem [16];
    logic [7:0]  count;
    // Address bit 25: no answer at all; bit 24: bus answers, no target
    wire logic   hangs  = req.addr[25];
    wire logic   absent = req.addr[24];

    always_ff @(posedge clk_sys) begin
        // Stale data flips every cycle so it is never mistaken for a result
        rsp.rdata <= ~rsp.rdata;
        rsp.done  <= 1'b0;
        rsp.fault <= 1'b0;
        if (rst) begin
            count     <= 8'h00;
            rsp.rdata <= 32'h5a5a5a5a;
        end else if (valid && !rsp.done && !hangs) begin
            if (count == delay) begin
                count     <= 8'h00;
                rsp.done  <= 1'b1;
                rsp.fault <= absent;
                if (req.write && !absent) mem[req.addr[3:0]] <= req.wdata;
                if (!req.write && !absent) rsp.rdata <= mem[req.addr[3:0]];
            end else begin
                count <= count + 8'h01;
            end
        end else begin
            count <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// File: tb/test_indirect_register_access_bridge.sv
`timescale 1ns/10ps
`default_nettype none
module test_indirect_register_access_bridge
    import mgmt_bridge_pkg::*;
;
    localparam logic [11:0] ADR = TARGET_ADDRESS_OFS;
    localparam logic [11:0] VAL = TRANSFER_VALUE_OFS;
    localparam logic [11:0] CMD = REQUEST_COMMAND_OFS;
    localparam logic [11:0] ERR = ERROR_DETAIL_OFS;
    localparam logic [11:0] PND = IRQ_PENDING_OFS;
    logic        clk_sys, rst, regWrite, regRead, rootValid, internalValid;
    logic        secondLevelIrq, coreIrq, sawInt;
    logic [11:0] regAddr;
    logic [31:0] regWdata, regRdata, v;
    bus_req_s    rootReq, internalReq;
    bus_rsp_s    rootRsp, internalRsp;
    logic [7:0]  rootDelay;
    int          failures, checks, cycles, t0;

    indirect_register_access_bridge u_dut (.clk_sys(clk_sys), .rst(rst),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata), .rootValid(rootValid),
        .rootReq(rootReq), .rootRsp(rootRsp), .internalValid(internalValid),
        .internalReq(internalReq), .internalRsp(internalRsp),
        .secondLevelIrq(secondLevelIrq), .coreIrq(coreIrq));
    bus_target_model u_root (.clk_sys(clk_sys), .rst(rst), .valid(rootValid),
        .req(rootReq), .delay(rootDelay), .rsp(rootRsp));
    bus_target_model u_int (.clk_sys(clk_sys), .rst(rst), .valid(internalValid),
        .req(internalReq), .delay(8'h01), .rsp(internalRsp));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Watchdog: the whole run needs about 150 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (internalValid === 1'b1) sawInt = 1'b1;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Idle edge after each strobe so no task re-raises it in the same step
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(posedge clk_sys) #1;
        regWrite = 1'b0;
        @(posedge clk_sys) #1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        regAddr = a;
        regRead = 1'b1;
        @(posedge clk_sys) #1;
        regRead = 1'b0;
        @(posedge clk_sys) #1;
        d = regRdata;
    endtask
    task automatic idle();
        int n;
        n = 0;
        rd(CMD, v);
        while (v[CMD_BUSY_BIT] === 1'b1 && n < 200) begin
            rd(CMD, v);
            n++;
        end
        check("busy", {31'h0, v[CMD_BUSY_BIT]}, 32'h0);
    endtask
    task automatic clr();
        wr(ERR, ERR_CLEAR_ALL);
        wr(PND, 32'h1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(ANSWER_WAIT_LIMIT_OFS, v);
        check("limit", v, WAIT_LIMIT_RST);
        rd(CMD, v);
        check("mask", {25'h0, v[14:12], v[7:4]}, 32'h0f);
        wr(CMD, 32'h100f3);
        rd(CMD, v);
        check("no launch", {27'h0, v[14:12], v[1:0]}, 32'h3);
        rd(12'h7c0, v);
        check("unmapped", v, 32'h0);
    endtask
    task automatic t_root();
        sawInt = 1'b0;
        wr(ADR, 32'h5);
        wr(VAL, 32'hc3a51e0f);
        wr(CMD, 32'h100f2);
        idle();
        check("req kind", {27'h0, rootReq.write, rootReq.byteMask}, 32'h1f);
        wr(VAL, 32'h0);
        wr(CMD, 32'h100f1);
        idle();
        check("flags", {29'h0, v[14:12]}, 32'h0);
        rd(VAL, v);
        check("rdata", v, 32'hc3a51e0f);
        check("route", {31'h0, sawInt}, 32'h0);
    endtask
    task automatic t_internal();
        wr(ADR, 32'h08004003);
        wr(VAL, 32'h1234abcd);
        wr(CMD, 32'h100f2);
        idle();
        wr(VAL, 32'h0);
        wr(CMD, 32'h100f1);
        idle();
        rd(VAL, v);
        check("int rdata", v, 32'h1234abcd);
        check("int used", {31'h0, sawInt}, 32'h1);
        sawInt = 1'b0;
        wr(ADR, 32'h08000100);
        wr(CMD, 32'h100f1);
        idle();
        check("excl", {31'h0, sawInt}, 32'h0);
        check("excl fault", {31'h0, v[CMD_FAULT_BIT]}, 32'h1);
        rd(ERR, v);
        check("excl err", {29'h0, v[31:30], v[3]}, 32'h4);
        clr();
    endtask
    task automatic t_timeout();
        wr(ANSWER_WAIT_LIMIT_OFS, 32'h8);
        wr(IRQ_ENABLE_OFS, 32'h1);
        wr(ADR, 32'h0a000010);
        wr(CMD, 32'h100f1);
        t0 = cycles;
        idle();
        check("to time", {31'h0, (cycles - t0 >= 8) && (cycles - t0 < 40)}, 32'h1);
        check("to flag", {31'h0, v[CMD_TIMEOUT_BIT]}, 32'h1);
        rd(ERR, v);
        check("to err", v, 32'h20000102);
        check("irq2", {31'h0, secondLevelIrq}, 32'h1);
        check("irqc", {31'h0, coreIrq}, 32'h1);
        rd(PND, v);
        check("pending", {31'h0, v[0]}, 32'h1);
        wr(ERR, ERR_CLEAR_ALL);
        rd(ERR, v);
        check("err clr", v, 32'h0);
        wr(PND, 32'h1);
        rd(PND, v);
        check("ack", {29'h0, v[0], secondLevelIrq, coreIrq}, 32'h0);
    endtask
    task automatic t_fault();
        wr(ADR, 32'h01000020);
        wr(CMD, 32'h100f2);
        idle();
        check("flt flag", {31'h0, v[CMD_FAULT_BIT]}, 32'h1);
        rd(ERR, v);
        check("flt err", v, 32'h50000208);
        clr();
    endtask
    task automatic t_busy();
        rootDelay = 8'd40;
        wr(ADR, 32'h5);
        wr(CMD, 32'h100f1);
        rd(CMD, v);
        check("busy up", {31'h0, v[CMD_BUSY_BIT]}, 32'h1);
        wr(CMD, 32'h100f1);
        idle();
        rd(ERR, v);
        check("cmd busy", {31'h0, v[ERR_BUSY_CMD]}, 32'h1);
        check("root to", {31'h0, v[ERR_TO_ROOT]}, 32'h1);
        clr();
        rootDelay = 8'd3;
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        {regWrite, regRead, sawInt} = 3'h0;
        regAddr = 12'h0;
        regWdata = 32'h0;
        rootDelay = 8'd3;
        {failures, checks, cycles} = 0;
        rst = 1'b1;
        repeat (16) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_reset();
        t_root();
        t_internal();
        t_timeout();
        t_fault();
        t_busy();
        stop_test();
    end
endmodule
`default_nettype wire
